/* hw/thso_pkg.sv */
// constants, frame layout and state encodings of the sensor serial readout
package thso_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_CLK_PERIOD_NS = 48;

    localparam int POWERUP_MS = 20;
    localparam int INTERVAL_A_MS = 10;
    localparam int INTERVAL_B_US = 330;
    localparam int INTERVAL_C_MS = 200;

    // least times round up to whole cycles
    localparam int POWERUP_CYC = (POWERUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INTERVAL_A_CYC = (INTERVAL_A_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INTERVAL_C_CYC = (INTERVAL_C_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // half of the serial clock period, rounded down, on the link clock
    localparam int SCK_HALF_CYC = (INTERVAL_B_US * 1000) / LINK_CLK_PERIOD_NS / 2;

    localparam logic [15:0] TEMP_OFFSET = 16'h0190;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] CRC_FLIP = 8'h30;
    localparam int FRAME_BITS = 32;
    localparam logic [4:0] LAST_BIT = 5'h1f;

    typedef struct packed {
        logic [15:0] temp;
        logic [7:0] rh;
        logic [7:0] crc;
    } thso_frame_t;

    localparam thso_frame_t FRAME_RESET = '{temp: 16'h0000, rh: 8'h00, crc: 8'h00};

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_CONV = 3'b001,
        ST_SEND = 3'b011,
        ST_ABORT = 3'b010,
        ST_SLEEP = 3'b110,
        ST_LEAD = 3'b111
    } thso_state_t;

    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_LOW = 2'b01,
        LS_HIGH = 2'b11
    } thso_lstate_t;

endpackage

/* hw/thso_crc.sv */
// check byte over the three measurement bytes, msb first
`timescale 1ns/1ps
module thso_crc
    import thso_pkg::*;
(
    input wire logic [15:0] temp,
    input wire logic [7:0] rh,
    output logic [7:0] crc
);
    always_comb begin
        logic [23:0] msg;
        logic [7:0] acc;
        msg = {temp, rh};
        acc = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            if (msg[i] != acc[7]) begin
                acc = {acc[6:0], 1'b1} ^ CRC_FLIP;
            end else begin
                acc = {acc[6:0], 1'b0};
            end
        end
        crc = acc;
    end
endmodule // thso_crc

/* hw/thso_top.sv */
// readout sequencer and serial link master of the temperature and humidity sensor
`timescale 1ns/1ps
// Behaviour
// - after 20 ms reset, measure, send if selected
// - reset pin active low, held high normally
// - select fall sends stored frame first
// - select low: alternate conversion and sending
// - select rise aborts frame immediately
// - after rise one conversion then sleep
// - module drives serial clock near 3 kHz
// - clock and data low after frame
// - data valid once clock is high
// - lead 10ms, clock period 330us, conversion 200ms
// - temp word msb first, humidity, check byte
// - temp word is tenths plus 0x0190
// - humidity byte is plain whole percent
// - bit-serial crc from zero, flip 4,5
module thso_top
    import thso_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int LEAD_CYCLES = INTERVAL_A_CYC,
    parameter int CONV_CYCLES = INTERVAL_C_CYC,
    parameter int SCK_HALF_CYCLES = SCK_HALF_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic select_n,
    input wire logic signed [15:0] sensor_temp_tenths,
    input wire logic [7:0] sensor_rh,
    output logic serial_clk,
    output logic serial_data_out,
    output logic converting,
    output logic sleeping
);
    // system clock domain
    logic sel_s1_reg, sel_s2_reg, sel_s3_reg;
    logic sel_low_reg, sel_low_next;
    logic sel_fall, sel_rise;
    thso_state_t state_reg, state_next;
    logic [31:0] timer_reg, timer_next;
    thso_frame_t stored_reg, stored_next;
    logic req_tgl_reg, req_tgl_next;
    logic abort_reg, abort_next;
    logic done_s1_reg, done_s2_reg, done_s3_reg;
    logic done_evt;
    logic conv_done;
    logic converting_reg, sleeping_reg;
    logic [15:0] temp_code;
    logic [7:0] crc_val;
    // link domain signals read across the boundary
    logic done_tgl_reg;

    // the reset pin is the module reset; it only ever arrives low on purpose
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_s1_reg <= 1'b1;
            sel_s2_reg <= 1'b1;
            sel_s3_reg <= 1'b1;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
        end else begin
            sel_s1_reg <= select_n;
            sel_s2_reg <= sel_s1_reg;
            sel_s3_reg <= sel_s2_reg;
            done_s1_reg <= done_tgl_reg;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
        end
    end

    // a select change counts only once two sampled stages agree
    always_comb begin
        sel_low_next = sel_low_reg;
        if (sel_s2_reg == sel_s3_reg) begin
            sel_low_next = ~sel_s2_reg;
        end
        sel_fall = sel_low_next & ~sel_low_reg;
        sel_rise = ~sel_low_next & sel_low_reg;
    end

    assign done_evt = done_s2_reg ^ done_s3_reg;
    assign conv_done = (state_reg == ST_CONV) && (timer_reg == 32'h0000_0000);
    assign temp_code = 16'(sensor_temp_tenths) + TEMP_OFFSET;

    thso_crc u_crc (
        .temp(temp_code),
        .rh(sensor_rh),
        .crc(crc_val)
    );

    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        stored_next = stored_reg;
        req_tgl_next = req_tgl_reg;
        abort_next = 1'b0;
        if (timer_reg != 32'h0000_0000) begin
            timer_next = timer_reg - 32'h0000_0001;
        end
        case (state_reg)
            ST_RESET: begin
                if (timer_reg == 32'h0000_0000) begin
                    state_next = ST_CONV;
                    timer_next = 32'(CONV_CYCLES - 1);
                end
            end
            ST_CONV: begin
                // a started conversion always completes, even after select rises
                if (conv_done) begin
                    stored_next.temp = temp_code;
                    stored_next.rh = sensor_rh;
                    stored_next.crc = crc_val;
                    if (sel_low_next) begin
                        state_next = ST_SEND;
                        req_tgl_next = ~req_tgl_reg;
                    end else begin
                        state_next = ST_SLEEP;
                    end
                end
            end
            ST_SEND: begin
                if (done_evt) begin
                    state_next = ST_CONV;
                    timer_next = 32'(CONV_CYCLES - 1);
                end else if (sel_rise) begin
                    state_next = ST_ABORT;
                    abort_next = 1'b1;
                end
            end
            ST_ABORT: begin
                // hold abort until the link end confirms it has stopped
                abort_next = 1'b1;
                if (done_evt) begin
                    state_next = ST_CONV;
                    abort_next = 1'b0;
                    timer_next = 32'(CONV_CYCLES - 1);
                end
            end
            ST_SLEEP: begin
                if (sel_fall) begin
                    state_next = ST_LEAD;
                    timer_next = 32'(LEAD_CYCLES - 1);
                end
            end
            ST_LEAD: begin
                if (sel_rise) begin
                    state_next = ST_CONV;
                    timer_next = 32'(CONV_CYCLES - 1);
                end else if (timer_reg == 32'h0000_0000) begin
                    state_next = ST_SEND;
                    req_tgl_next = ~req_tgl_reg;
                end
            end
            default: begin
                state_next = ST_RESET;
                timer_next = 32'(POWERUP_CYCLES - 1);
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RESET;
            timer_reg <= 32'(POWERUP_CYCLES - 1);
            stored_reg <= FRAME_RESET;
            req_tgl_reg <= 1'b0;
            abort_reg <= 1'b0;
            sel_low_reg <= 1'b0;
            converting_reg <= 1'b0;
            sleeping_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            stored_reg <= stored_next;
            req_tgl_reg <= req_tgl_next;
            abort_reg <= abort_next;
            sel_low_reg <= sel_low_next;
            converting_reg <= (state_next == ST_CONV);
            sleeping_reg <= (state_next == ST_SLEEP);
        end
    end

    assign converting = converting_reg;
    assign sleeping = sleeping_reg;

    // link clock domain
    logic req_s1_reg, req_s2_reg, req_s3_reg;
    logic abort_s1_reg, abort_s2_reg, abort_s3_reg;
    logic req_evt, abort_seen;
    thso_lstate_t lstate_reg, lstate_next;
    logic [31:0] half_reg, half_next;
    logic [4:0] bit_reg, bit_next;
    logic [FRAME_BITS-1:0] shift_reg, shift_next;
    logic sck_reg, sck_next;
    logic sdo_reg, sdo_next;
    logic done_tgl_next;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_s3_reg <= 1'b0;
            abort_s1_reg <= 1'b0;
            abort_s2_reg <= 1'b0;
            abort_s3_reg <= 1'b0;
        end else begin
            req_s1_reg <= req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            abort_s1_reg <= abort_reg;
            abort_s2_reg <= abort_s1_reg;
            abort_s3_reg <= abort_s2_reg;
        end
    end

    assign req_evt = req_s2_reg ^ req_s3_reg;
    assign abort_seen = abort_s2_reg & abort_s3_reg;

    // stored frame stays still while a request is open, so it is taken whole
    always_comb begin
        lstate_next = lstate_reg;
        half_next = half_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        sck_next = sck_reg;
        sdo_next = sdo_reg;
        done_tgl_next = done_tgl_reg;
        if (half_reg != 32'h0000_0000) begin
            half_next = half_reg - 32'h0000_0001;
        end
        if (lstate_reg != LS_IDLE && abort_seen) begin
            lstate_next = LS_IDLE;
            sck_next = 1'b0;
            sdo_next = 1'b0;
            done_tgl_next = ~done_tgl_reg;
        end else begin
            case (lstate_reg)
                LS_IDLE: begin
                    if (req_evt) begin
                        shift_next = stored_reg;
                        sdo_next = stored_reg[FRAME_BITS-1];
                        sck_next = 1'b0;
                        bit_next = 5'h00;
                        half_next = 32'(SCK_HALF_CYCLES - 1);
                        lstate_next = LS_LOW;
                    end
                end
                LS_LOW: begin
                    if (half_reg == 32'h0000_0000) begin
                        sck_next = 1'b1;
                        half_next = 32'(SCK_HALF_CYCLES - 1);
                        lstate_next = LS_HIGH;
                    end
                end
                LS_HIGH: begin
                    if (half_reg == 32'h0000_0000) begin
                        sck_next = 1'b0;
                        if (bit_reg == LAST_BIT) begin
                            sdo_next = 1'b0;
                            lstate_next = LS_IDLE;
                            done_tgl_next = ~done_tgl_reg;
                        end else begin
                            // new bit goes out on the falling edge only
                            shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0};
                            sdo_next = shift_reg[FRAME_BITS-2];
                            bit_next = bit_reg + 5'h01;
                            half_next = 32'(SCK_HALF_CYCLES - 1);
                            lstate_next = LS_LOW;
                        end
                    end
                end
                default: begin
                    lstate_next = LS_IDLE;
                    sck_next = 1'b0;
                    sdo_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lstate_reg <= LS_IDLE;
            half_reg <= 32'h0000_0000;
            bit_reg <= 5'h00;
            shift_reg <= '0;
            sck_reg <= 1'b0;
            sdo_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end else begin
            lstate_reg <= lstate_next;
            half_reg <= half_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            sck_reg <= sck_next;
            sdo_reg <= sdo_next;
            done_tgl_reg <= done_tgl_next;
        end
    end

    assign serial_clk = sck_reg;
    assign serial_data_out = sdo_reg;

    property p_powerup_conv;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == ST_RESET && timer_reg == 32'h0000_0000) |=> (state_reg == ST_CONV);
    endproperty
    a_powerup_conv: assert property (p_powerup_conv) else $error("no conversion after reset");

    property p_wake_lead;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && sel_fall) |=> (state_reg == ST_LEAD);
    endproperty
    a_wake_lead: assert property (p_wake_lead) else $error("select fall did not wake");

    property p_conv_send;
        @(posedge clk) disable iff (!rst_n)
        (conv_done && sel_low_next) |=> (state_reg == ST_SEND) && $changed(req_tgl_reg);
    endproperty
    a_conv_send: assert property (p_conv_send) else $error("no frame after conversion");

    property p_abort_conv;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == ST_ABORT && done_evt) |=> (state_reg == ST_CONV)
            && (timer_reg == 32'(CONV_CYCLES - 1));
    endproperty
    a_abort_conv: assert property (p_abort_conv) else $error("no final conversion after abort");

    property p_temp_code;
        @(posedge clk) disable iff (!rst_n)
        conv_done |=> (stored_reg.temp == 16'($past(sensor_temp_tenths)) + TEMP_OFFSET)
            && (stored_reg.rh == $past(sensor_rh));
    endproperty
    a_temp_code: assert property (p_temp_code) else $error("stored frame coding wrong");

    property p_link_abort;
        @(posedge link_clk) disable iff (!rst_n)
        (lstate_reg != LS_IDLE && abort_seen) |=> (lstate_reg == LS_IDLE) && !sck_reg;
    endproperty
    a_link_abort: assert property (p_link_abort) else $error("frame not stopped on abort");

    property p_idle_low;
        @(posedge link_clk) disable iff (!rst_n)
        (lstate_reg == LS_IDLE) |-> (!sck_reg && !sdo_reg);
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("lines not low after frame");

    property p_data_on_low;
        @(posedge link_clk) disable iff (!rst_n)
        $changed(sdo_reg) |-> !sck_reg && !$past(sck_reg) || ($past(sck_reg) && !sck_reg);
    endproperty
    a_data_on_low: assert property (p_data_on_low) else $error("data moved while clock high");

    property p_first_bit;
        @(posedge link_clk) disable iff (!rst_n)
        (lstate_reg == LS_IDLE && req_evt) |=>
            (sdo_reg == $past(stored_reg[FRAME_BITS-1])) && (lstate_reg == LS_LOW) && !sck_reg;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("frame does not start msb first");

endmodule // thso_top

/* testbench/thso_mcu_model.sv */
// receiving controller model: collects the serial frame after each clock rise
`timescale 1ns/1ps
module thso_mcu_model
    import thso_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic select_n,
    input wire logic serial_clk,
    input wire logic serial_data_out,
    output logic frame_valid,
    output thso_frame_t frame
);
    logic sck_prev;
    logic [4:0] nbits;
    logic [30:0] shift;
    // partial bits are dropped once select is released, so an aborted frame never surfaces
    always @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev <= 1'b0;
            nbits <= 5'h00;
            shift <= '0;
            frame_valid <= 1'b0;
            frame <= FRAME_RESET;
        end else begin
            frame_valid <= 1'b0;
            sck_prev <= serial_clk;
            if (select_n) begin
                nbits <= 5'h00;
            end else if (serial_clk && !sck_prev) begin
                shift <= {shift[29:0], serial_data_out};
                nbits <= nbits + 5'h01;
                if (nbits == LAST_BIT) begin
                    frame <= {shift, serial_data_out};
                    frame_valid <= 1'b1;
                end
            end
        end
    end
endmodule // thso_mcu_model

/* testbench/test_temp_humidity_serial_output.sv */
// self-checking bench of the sensor serial readout
`timescale 1ns/1ps
module test_temp_humidity_serial_output
    import thso_pkg::*;
;
    localparam int HALF = 3;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n;
    logic select_n;
    logic [15:0] tenths;
    logic [7:0] rh;
    logic serial_clk;
    logic serial_data_out;
    logic converting;
    logic sleeping;
    logic frame_valid;
    thso_frame_t frame;
    thso_frame_t exp_q[$];
    int num_errors = 0;
    int compares = 0;
    int rx_count = 0;
    int cycles = 0;
    int link_cnt = 0;
    int k;
    logic [15:0] lfsr = 16'h0056;
    logic sck_prev = 1'b0;
    logic sdo_prev = 1'b0;

    always #5 clk = ~clk;
    // odd offset keeps the link edges away from the system edges
    initial begin
        #3.7;
        forever #24 link_clk = ~link_clk;
    end

    thso_top #(.POWERUP_CYCLES(20), .LEAD_CYCLES(10), .CONV_CYCLES(50),
        .SCK_HALF_CYCLES(HALF)) dut_u (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
        .select_n(select_n), .sensor_temp_tenths(tenths), .sensor_rh(rh),
        .serial_clk(serial_clk), .serial_data_out(serial_data_out),
        .converting(converting), .sleeping(sleeping));

    thso_mcu_model mcu_u (.link_clk(link_clk), .rst_n(rst_n), .select_n(select_n),
        .serial_clk(serial_clk), .serial_data_out(serial_data_out),
        .frame_valid(frame_valid), .frame(frame));

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic thso_frame_t expect_frame(input logic [15:0] t, input logic [7:0] h);
        thso_frame_t f;
        logic [23:0] m;
        f.temp = t + 16'h0190;
        f.rh = h;
        f.crc = 8'h00;
        m = {f.temp, h};
        for (int i = 23; i >= 0; i--) begin
            if (m[i] != f.crc[7]) f.crc = {f.crc[6:0], 1'b1} ^ 8'h30;
            else f.crc = {f.crc[6:0], 1'b0};
        end
        return f;
    endfunction

    task complete_run;
        $display("counts: %0d compares, %0d mismatches", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task check_frame(input string name, input thso_frame_t e, input thso_frame_t g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task check_bit(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", name, e, g);
        end
    endtask

    task wait_frames(input int n);
        int t;
        int w;
        t = rx_count + n;
        w = 0;
        while (rx_count < t && w < 8000) begin
            @(negedge clk);
            w++;
        end
        check_bit("frame_arrived", 1'b1, rx_count >= t);
        if (rx_count < t) begin
            // a silent module is forced through reset, as the controller would
            rst_n = 1'b0;
            repeat (12) @(negedge clk);
            rst_n = 1'b1;
        end
    endtask

    // bounded wait on sleeping; the caller checks the level
    task wait_sleep;
        k = 0;
        while (sleeping !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            complete_run();
        end
    end

    // new sensor values at each conversion start, taken by the design at its end
    always @(posedge converting) begin
        @(negedge clk);
        lfsr = lfsr_next(lfsr);
        tenths = (lfsr % 16'h044d) - 16'h0190;
        lfsr = lfsr_next(lfsr);
        rh = 8'(lfsr % 16'h0065);
    end

    always @(negedge converting) begin
        if (rst_n === 1'b1) exp_q.push_back(expect_frame(tenths, rh));
    end

    always @(posedge link_clk) begin
        if (frame_valid === 1'b1) begin
            rx_count++;
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("[ERR] frame expected none seen %h", frame);
            end else check_frame("frame", exp_q.pop_front(), frame);
        end
        if (sck_prev && serial_clk) check_bit("data_stable", sdo_prev, serial_data_out);
        if (serial_clk && !sck_prev) begin
            // gaps between frames run far longer than 8 link cycles
            if (link_cnt < 8) check_bit("sck_period", 1'b1, link_cnt == 2 * HALF - 1);
            link_cnt = 0;
        end else link_cnt++;
        sck_prev = serial_clk;
        sdo_prev = serial_data_out;
    end

    initial begin
        rst_n = 1'b0;
        select_n = 1'b1;
        tenths = 16'h0000;
        rh = 8'h00;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        k = 0;
        while (converting !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        check_bit("powerup_time", 1'b1, k >= 20 && k <= 23);
        wait_sleep();
        check_bit("sleep_after_powerup", 1'b1, sleeping);
        $display("test powerup done");
        select_n = 1'b0;
        wait_frames(3);
        $display("test continuous done");
        @(negedge converting);
        repeat (5) @(posedge serial_clk);
        @(negedge clk);
        select_n = 1'b1;
        void'(exp_q.pop_front());
        repeat (40) @(negedge clk);
        check_bit("sck_after_abort", 1'b0, serial_clk);
        check_bit("sdo_after_abort", 1'b0, serial_data_out);
        wait_sleep();
        check_bit("sleep_after_abort", 1'b1, sleeping);
        check_bit("conv_after_abort", 1'b0, converting);
        check_bit("one_final_conv", 1'b1, exp_q.size() == 1);
        $display("test abort done");
        // a rise during the lead wait skips the frame and runs the last conversion
        select_n = 1'b0;
        repeat (6) @(negedge clk);
        select_n = 1'b1;
        wait_sleep();
        check_bit("sleep_after_lead", 1'b1, sleeping);
        check_bit("lead_conv_only", 1'b1, exp_q.size() == 2);
        void'(exp_q.pop_front());
        $display("test lead abort done");
        select_n = 1'b0;
        wait_frames(1);
        repeat (10) @(negedge clk);
        // controller recovery: forced reset, then a fresh measurement
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        check_bit("sck_in_reset", 1'b0, serial_clk);
        check_bit("conv_in_reset", 1'b0, converting);
        exp_q.delete();
        rst_n = 1'b1;
        wait_frames(1);
        repeat (20) @(negedge clk);
        check_bit("sck_idle", 1'b0, serial_clk);
        check_bit("sdo_idle", 1'b0, serial_data_out);
        $display("test reset done");
        complete_run();
    end
endmodule // test_temp_humidity_serial_output
